// file: src/adc_ctrl_pkg.sv
// Package: register map, field layout and timing of the converter control
package adc_ctrl_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] RUN_OFS = 8'h00;
  localparam logic [7:0] CTL1_OFS = 8'h04;
  localparam logic [7:0] AE_LOW_OFS = 8'h08;
  localparam logic [7:0] AE_HIGH_OFS = 8'h0c;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [7:0] XFER_CTL_OFS = 8'h14;
  localparam logic [7:0] XFER_CNT_OFS = 8'h18;
  localparam logic [7:0] START_ADDR_OFS = 8'h1c;
  localparam logic [7:0] STATUS_OFS = 8'h20;
  localparam logic [7:0] MASK_OFS = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RUN_ENABLE_BIT = 0;
  localparam int RUN_START_BIT = 1;
  localparam int DIV_LSB = 5;
  localparam int SRC_LSB = 3;
  localparam int MODE_LSB = 1;
  localparam int BUSY_BIT = 0;
  localparam int INCH_LSB = 12;
  localparam int FORMAT_BIT = 9;
  localparam int TWO_BLOCK_BIT = 3;
  localparam int CONT_BIT = 2;
  localparam int BLOCK_ONE_BIT = 1;
  localparam int FETCH_BIT = 0;
  localparam int IFG_BIT = 0;
  localparam int XFER_DONE_BIT = 1;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] CTL1_WMASK = 16'hfffe;
  localparam logic [7:0] AE_HIGH_WMASK = 8'hf0;
  localparam logic [7:0] XFER_CTL_WMASK = 8'h0d;
  localparam logic [15:0] START_ADDR_RESET = 16'h0200;
  localparam logic [15:0] START_ADDR_WMASK = 16'hfffe;
  localparam logic [1:0] STATUS_WMASK = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [3:0] CONV_TICKS = 4'hd;

  typedef enum logic [1:0] {
    SRC_OSC, SRC_AUX, SRC_MASTER, SRC_SUB
  } clk_src_e;

  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_SEQ, MODE_REPEAT_SINGLE, MODE_REPEAT_SEQ
  } seq_mode_e;
endpackage : adc_ctrl_pkg

// file: src/adc_seq_if.sv
// Interface: configuration and results between control and sequencer
interface adc_seq_if;
  import adc_ctrl_pkg::*;
  clk_src_e src;
  logic [2:0] div;
  seq_mode_e mode;
  logic [3:0] highCh;
  logic enable;
  logic start;
  logic busy;
  logic resultStrobe;
  logic [9:0] result;
  logic [3:0] channel;

  modport ctrl (
    output src, div, mode, highCh, enable, start,
    input busy, resultStrobe, result, channel
  );
  modport seq (
    input src, div, mode, highCh, enable, start,
    output busy, resultStrobe, result, channel
  );
endinterface : adc_seq_if

// file: src/converter_sequencer.sv
// Conversion clock selection, division and channel sequencing
module converter_sequencer
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] srcTicks,
  input wire logic [9:0] analogCode,
  adc_seq_if.seq seqIf
);
  typedef enum logic [1:0] {S_IDLE, S_CONV} seq_state_e;

  seq_state_e state;
  logic [2:0] divCnt;
  logic [3:0] tickCnt;
  logic convTick;
  logic lastTick;

  // source pick
  // Compare with >= so a smaller divider takes hold at the next tick
  assign convTick = srcTicks[seqIf.src] && divCnt >= seqIf.div;
  assign lastTick = convTick && tickCnt == CONV_TICKS - 4'h1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCnt <= 3'h0;
    end else if (srcTicks[seqIf.src]) begin
      divCnt <= (divCnt >= seqIf.div) ? 3'h0 : 3'(divCnt + 3'h1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      tickCnt <= 4'h0;
      seqIf.channel <= 4'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (seqIf.start && seqIf.enable) begin
            state <= S_CONV;
            tickCnt <= 4'h0;
            seqIf.channel <= seqIf.highCh;
          end
        end
        S_CONV: begin
          if (convTick) begin
            tickCnt <= 4'(tickCnt + 4'h1);
          end
          if (lastTick) begin
            tickCnt <= 4'h0;
            unique case (seqIf.mode)
              MODE_SINGLE: state <= S_IDLE;
              MODE_SEQ: begin
                if (seqIf.channel == 4'h0) begin
                  state <= S_IDLE;
                end else begin
                  seqIf.channel <= 4'(seqIf.channel - 4'h1);
                end
              end
              MODE_REPEAT_SINGLE: begin
                // Repeats stop cleanly once software drops enable
                if (!seqIf.enable) begin
                  state <= S_IDLE;
                end
              end
              MODE_REPEAT_SEQ: begin
                if (seqIf.channel != 4'h0) begin
                  seqIf.channel <= 4'(seqIf.channel - 4'h1);
                end else if (seqIf.enable) begin
                  seqIf.channel <= seqIf.highCh;
                end else begin
                  state <= S_IDLE;
                end
              end
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Result capture at the last conversion tick
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seqIf.resultStrobe <= 1'b0;
      seqIf.result <= 10'h000;
    end else begin
      seqIf.resultStrobe <= state == S_CONV && lastTick;
      if (state == S_CONV && lastTick) begin
        seqIf.result <= analogCode;
      end
    end
  end

  assign seqIf.busy = state != S_IDLE;
endmodule : converter_sequencer

// file: src/adc_control_and_result_transfer.sv
// Converter control registers, result formatting and result transfer
module adc_control_and_result_transfer
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] srcTicks,
  input wire logic [9:0] analogCode,
  output logic [3:0] channel,
  output logic [15:0] analogEnable,
  output logic memWrite,
  output logic [15:0] memAddr,
  output logic [15:0] memData,
  output logic irq
);
  // ****************************************************************
  // Registers and wires
  // ****************************************************************
  adc_seq_if seqIf ();

  logic runEnable;
  logic startPulse;
  logic [15:0] convControlOne;
  logic [7:0] analogEnableLow;
  logic [7:0] analogEnableHigh;
  logic [9:0] resultRaw;
  logic twoBlock;
  logic contXfer;
  logic blockOne;
  logic fetchCtl;
  logic [7:0] xferCount;
  logic [15:0] startAddr;
  logic xferArmed;
  logic [8:0] xferIdx;
  logic [1:0] status;
  logic [1:0] mask;
  logic wrAccess;
  logic rdAccess;
  logic mapped;
  logic [31:0] readData;
  logic [15:0] fmtResult;
  logic [15:0] fmtNew;
  logic [8:0] blockEnd;
  logic [8:0] lastIdx;
  logic xferGo;
  logic setIfg;
  logic setDone;

  // ****************************************************************
  // Sequencer hookup
  // ****************************************************************
  assign seqIf.src = clk_src_e'(convControlOne[SRC_LSB +: 2]);
  assign seqIf.div = convControlOne[DIV_LSB +: 3];
  assign seqIf.mode = seq_mode_e'(convControlOne[MODE_LSB +: 2]);
  assign seqIf.highCh = convControlOne[INCH_LSB +: 4];
  assign seqIf.enable = runEnable;
  assign seqIf.start = startPulse;

  converter_sequencer sequencer (
    .ref_clk(ref_clk),
    .rst(rst),
    .srcTicks(srcTicks),
    .analogCode(analogCode),
    .seqIf(seqIf)
  );

  // ****************************************************************
  // Result formatting
  // ****************************************************************
  // Flipping the top bit turns offset binary into two's complement
  function automatic logic [15:0] formatResult(
    input logic [9:0] raw,
    input logic twosComp
  );
    if (twosComp) begin
      return {~raw[9], raw[8:0], 6'h00};
    end
    return {6'h00, raw};
  endfunction : formatResult

  assign fmtResult = formatResult(resultRaw, convControlOne[FORMAT_BIT]);
  assign fmtNew = formatResult(seqIf.result, convControlOne[FORMAT_BIT]);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Write lands on the completing edge, when pready is already high
  assign wrAccess = psel && penable && pready && pwrite;
  assign rdAccess = psel && penable && !pready;

  // Read mux; a hole in the map is flagged as an error below
  always_comb begin
    mapped = 1'b1;
    readData = 32'h0000_0000;
    unique case (paddr)
      RUN_OFS: readData = {31'h0, runEnable};
      CTL1_OFS: readData = {16'h0, convControlOne[15:1], seqIf.busy};
      AE_LOW_OFS: readData = {24'h0, analogEnableLow};
      AE_HIGH_OFS: readData = {24'h0, analogEnableHigh};
      RESULT_OFS: readData = {16'h0, fmtResult};
      XFER_CTL_OFS: begin
        readData = {28'h0, twoBlock, contXfer, blockOne, fetchCtl};
      end
      XFER_CNT_OFS: readData = {24'h0, xferCount};
      START_ADDR_OFS: readData = {16'h0, startAddr[15:1], 1'b0};
      STATUS_OFS: readData = {30'h0, status};
      MASK_OFS: readData = {30'h0, mask};
      default: mapped = 1'b0;
    endcase
  end

  // Two-cycle access; unmapped reads zero with an error
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rdAccess;
      pslverr <= rdAccess && !mapped;
      if (rdAccess) begin
        prdata <= pwrite ? 32'h0000_0000 : readData;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Writes land on the completing edge; read-only bits are not stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      runEnable <= 1'b0;
      startPulse <= 1'b0;
      convControlOne <= CTL1_RESET;
      analogEnableLow <= 8'h00;
      analogEnableHigh <= 8'h00;
      twoBlock <= 1'b0;
      contXfer <= 1'b0;
      fetchCtl <= 1'b0;
      xferCount <= 8'h00;
      mask <= 2'h0;
    end else begin
      startPulse <= wrAccess && paddr == RUN_OFS && pwdata[RUN_START_BIT];
      if (wrAccess) begin
        unique case (paddr)
          RUN_OFS: runEnable <= pwdata[RUN_ENABLE_BIT];
          CTL1_OFS: convControlOne <= pwdata[15:0] & CTL1_WMASK;
          AE_LOW_OFS: analogEnableLow <= pwdata[7:0];
          AE_HIGH_OFS: analogEnableHigh <= pwdata[7:0] & AE_HIGH_WMASK;
          XFER_CTL_OFS: begin
            twoBlock <= pwdata[TWO_BLOCK_BIT];
            contXfer <= pwdata[CONT_BIT];
            fetchCtl <= pwdata[FETCH_BIT];
          end
          XFER_CNT_OFS: xferCount <= pwdata[7:0];
          MASK_OFS: mask <= pwdata[1:0] & STATUS_WMASK;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      analogEnable <= 16'h0000;
      channel <= 4'h0;
    end else begin
      analogEnable <= {analogEnableHigh[7:4], 4'h0, analogEnableLow};
      channel <= seqIf.channel;
    end
  end

  // ****************************************************************
  // Result transfer
  // ****************************************************************
  // Indices count words; block one ends at count minus one
  assign blockEnd = {1'b0, xferCount} - 9'h001;
  assign lastIdx = twoBlock ? 9'({xferCount, 1'b0} - 9'h001) : blockEnd;
  assign xferGo = seqIf.resultStrobe && xferArmed && xferCount != 8'h00;

  // Latest raw result, kept for the result register
  // Software sees the newest result even with the transfer off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resultRaw <= 10'h000;
    end else if (seqIf.resultStrobe) begin
      resultRaw <= seqIf.result;
    end
  end

  // A rewrite of the start address restarts at index zero
  // armed only by address write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      startAddr <= START_ADDR_RESET;
      xferArmed <= 1'b0;
      xferIdx <= 9'h000;
      blockOne <= 1'b0;
    end else if (wrAccess && paddr == START_ADDR_OFS) begin
      startAddr <= pwdata[15:0] & START_ADDR_WMASK;
      xferArmed <= 1'b1;
      xferIdx <= 9'h000;
    end else if (xferGo) begin
      xferIdx <= 9'(xferIdx + 9'h001);
      if (twoBlock && xferIdx == blockEnd) begin
        blockOne <= 1'b1;
      end
      if (xferIdx == lastIdx) begin
        if (twoBlock) begin
          blockOne <= 1'b0;
        end
        xferIdx <= 9'h000;
        if (!contXfer) begin
          xferArmed <= 1'b0;
        end
      end
    end
  end

  // Word-aligned memory writes of formatted results
  // Address steps by two bytes per word from the start address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      memWrite <= 1'b0;
      memAddr <= 16'h0000;
      memData <= 16'h0000;
    end else begin
      memWrite <= xferGo;
      if (xferGo) begin
        memAddr <= 16'(startAddr + {6'h00, xferIdx, 1'b0});
        memData <= fmtNew;
      end
    end
  end

  // ****************************************************************
  // Status and interrupt
  // ****************************************************************
  // Flag on every result without transfer, else at each block end
  assign setIfg = seqIf.resultStrobe
    && (!(xferArmed && xferCount != 8'h00)
      || xferIdx == lastIdx || (twoBlock && xferIdx == blockEnd));
  assign setDone = xferGo && xferIdx == lastIdx && !contXfer;

  // Set beats a simultaneous write-one clear
  // Later assignments win, so set terms come after the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      if (wrAccess && paddr == STATUS_OFS) begin
        status <= status & ~pwdata[1:0];
      end
      if (setIfg) begin
        status[IFG_BIT] <= 1'b1;
      end
      if (setDone) begin
        status[XFER_DONE_BIT] <= 1'b1;
      end
    end
  end

  // Registered so the pin is glitch free; one cycle behind status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
endmodule : adc_control_and_result_transfer

// file: testbench/adc_ctrl_chk.sv
// Checker: bus and output relations of the converter control block
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] analogEnable,
  input wire logic memWrite,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memData
);
  logic wrOk, armed, fmt;
  logic [7:0] cnt;

  // Completed good write
  assign wrOk = psel && penable && pready && pwrite && !pslverr;

  // Shadow of fields that shape a transfer; format follows every good CTL1 write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      fmt <= 1'b0;
      cnt <= 8'h00;
    end else if (wrOk) begin
      if (paddr == START_ADDR_OFS) armed <= 1'b1;
      if (paddr == CTL1_OFS) fmt <= pwdata[FORMAT_BIT];
      if (paddr == XFER_CNT_OFS) cnt <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  ready_pulse_a:
    assert property (pready |=> !pready) else $error("pready held");
  ready_late_a:
    assert property ($rose(penable) && psel |=> pready)
    else $error("pready not on second access cycle");
  unmapped_err_a:
    assert property (psel && penable && !pready && paddr > MASK_OFS
      |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  upper_enable_a:
    assert property (analogEnable[11:8] == 4'h0) else $error("gap enabled");
  binary_fmt_a:
    assert property (memWrite && !fmt |-> memData[15:10] == 6'h00)
    else $error("binary top bits set");
  twos_fmt_a:
    assert property (memWrite && fmt |-> memData[5:0] == 6'h00)
    else $error("signed low bits set");
  addr_align_a:
    assert property (memWrite |-> !memAddr[0]) else $error("odd address");
  needs_arm_a:
    assert property (memWrite |-> armed) else $error("write before arm");
  count_zero_a:
    assert property (memWrite |-> cnt != 8'h00) else $error("count zero");
endmodule : adc_ctrl_chk

// file: testbench/tb.sv
// Testbench: register, conversion and transfer scenarios
module tb
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] srcTicks = 4'h0, tickCnt = 4'h0;
  logic [9:0] analogCode = 10'h2a5;
  logic [31:0] prdata;
  logic pready, pslverr, memWrite, irq;
  logic [3:0] channel;
  logic [15:0] analogEnable, memAddr, memData;
  logic [15:0] adrQ[$];
  logic lastErr = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;

  adc_control_and_result_transfer adc_control_and_result_transfer_i (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srcTicks(srcTicks),
    .analogCode(analogCode), .channel(channel),
    .analogEnable(analogEnable), .memWrite(memWrite), .memAddr(memAddr),
    .memData(memData), .irq(irq));

  always #2 ref_clk = ~ref_clk;

  // Sources tick at 1/1, 1/2, 1/3, 1/4 so a wrong pick changes timing
  always @(posedge ref_clk) begin
    tickCnt <= (tickCnt == 4'hb) ? 4'h0 : tickCnt + 4'h1;
    srcTicks <= {tickCnt[1:0] == 2'h0, tickCnt % 4'h3 == 4'h0,
                 !tickCnt[0], 1'b1};
  end

  // Log transfer addresses mid-cycle, where they are settled
  always @(negedge ref_clk) if (memWrite === 1'b1) adrQ.push_back(memAddr);

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // A bound that ran out ends the run as a mismatch
  task automatic guard(input int i);
    if (i >= 3000) begin
      n_mismatch++;
      complete_run();
    end
  endtask : guard

  // One APB transfer; pready, data and error taken at one rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 3000);
    guard(i);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rd

  task automatic waitWr(input int k);
    int i;
    for (i = 0; i < 3000 && adrQ.size() < k; i++) @(negedge ref_clk);
    guard(i);
  endtask : waitWr

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    int n;
    logic [31:0] v;
    logic [15:0] cfg[4];
    int per[4];
    cfg = '{16'h0018, 16'h02e0, 16'h0048, 16'h0030};
    per = '{4, 8, 6, 6};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(CTL1_OFS, 32'h0);
    rd(START_ADDR_OFS, 32'h200);
    check({31'h0, lastErr}, 32'h0);
    wr(START_ADDR_OFS, 32'hffff);
    rd(START_ADDR_OFS, 32'hfffe);
    wr(AE_HIGH_OFS, 32'hff);
    rd(AE_HIGH_OFS, 32'hf0);
    check({16'h0, analogEnable}, 32'hf000);
    wr(XFER_CTL_OFS, 32'hff);
    rd(XFER_CTL_OFS, 32'h0d);
    wr(XFER_CTL_OFS, 32'h0);
    rd(8'h28, 32'h0);
    check({31'h0, lastErr}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      v = 32'((7 - s) << DIV_LSB | s << SRC_LSB | s << MODE_LSB);
      wr(CTL1_OFS, v);
      rd(CTL1_OFS, v);
    end
    $display("Test registers done");
    wr(MASK_OFS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(STATUS_OFS, 32'h3);
      wr(CTL1_OFS, {16'h0, cfg[k]});
      wr(RUN_OFS, 32'h3);
      rd(CTL1_OFS, {16'h0, cfg[k] | 16'h1});
      for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge ref_clk);
      guard(n);
      check(32'(n > 13 * per[k] - 9 && n < 13 * per[k] + 9), 32'h1);
      v = cfg[k][FORMAT_BIT] ? {16'h0, ~analogCode[9], analogCode[8:0], 6'h0}
            : {22'h0, analogCode};
      rd(RESULT_OFS, v);
      rd(CTL1_OFS, {16'h0, cfg[k]});
    end
    // Masking hides a sticky flag; a written one clears it
    wr(MASK_OFS, 32'h0);
    rd(STATUS_OFS, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(MASK_OFS, 32'h1);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("Test conversion done");
    wr(XFER_CNT_OFS, 32'h2);
    wr(CTL1_OFS, 32'h4);
    wr(START_ADDR_OFS, 32'h300);
    wr(RUN_OFS, 32'h3);
    waitWr(2);
    repeat (100) @(negedge ref_clk);
    wr(RUN_OFS, 32'h0);
    check(32'(adrQ.size()), 32'h2);
    check({16'h0, adrQ[1]}, 32'h302);
    rd(STATUS_OFS, 32'h3);
    check({16'h0, memData}, {22'h0, analogCode});
    repeat (60) @(negedge ref_clk);
    adrQ.delete();
    wr(CTL1_OFS, 32'h3002);
    wr(XFER_CTL_OFS, 32'h8);
    wr(START_ADDR_OFS, 32'h400);
    wr(RUN_OFS, 32'h3);
    waitWr(2);
    rd(XFER_CTL_OFS, 32'ha);
    check({28'h0, channel}, 32'h1);
    waitWr(4);
    repeat (100) @(negedge ref_clk);
    check(32'(adrQ.size()), 32'h4);
    check({16'h0, adrQ[3]}, 32'h406);
    rd(XFER_CTL_OFS, 32'h8);
    $display("Test block transfer done");
    adrQ.delete();
    wr(CTL1_OFS, 32'h1006);
    wr(XFER_CTL_OFS, 32'h4);
    wr(XFER_CNT_OFS, 32'h1);
    wr(START_ADDR_OFS, 32'h500);
    wr(RUN_OFS, 32'h3);
    waitWr(3);
    wr(RUN_OFS, 32'h0);
    check({16'h0, adrQ[2]}, 32'h500);
    repeat (60) @(negedge ref_clk);
    adrQ.delete();
    wr(XFER_CNT_OFS, 32'h0);
    wr(START_ADDR_OFS, 32'h600);
    wr(STATUS_OFS, 32'h3);
    wr(CTL1_OFS, 32'h0);
    wr(RUN_OFS, 32'h3);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge ref_clk);
    guard(n);
    check(32'(adrQ.size()), 32'h0);
    $display("Test continuous done");
    complete_run();
  end
endmodule : tb

bind adc_control_and_result_transfer adc_ctrl_chk adc_ctrl_chk_i (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .analogEnable(analogEnable),
  .memWrite(memWrite), .memAddr(memAddr), .memData(memData));
